/* File: inc/rcd_pkg.sv */
// Shared constants and types for the RISC core decode and execute block.
// Assumes a 14-bit program word, 8-bit data and a 7-bit file address.
package rcd_pkg;
  // Program counter and return stack geometry.
  localparam int PC_W = 11;
  localparam int STK_D = 8;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] INT_VECTOR = 11'h004;
  // Instruction classes held in the two top bits of the word.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Byte-oriented op field codes.
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  // Bit-oriented sub codes in bits 11:10.
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIPCLR = 2'h2;
  localparam logic [1:0] BOP_SKIPSET = 2'h3;
  // Fixed control words.
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_RETFROMINT = 14'h0009;
  localparam logic [13:0] W_STANDBY = 14'h0063;
  localparam logic [13:0] W_WDOGCLR = 14'h0064;
  // File addresses that get special treatment.
  localparam logic [6:0] FA_TIMER_ZERO_COUNT = 7'h01;
  localparam logic [6:0] FA_PORT_A = 7'h05;
  localparam logic [6:0] FA_PORT_B = 7'h06;
  // Software register indexes.
  localparam logic [2:0] RA_CTRL = 3'h0;
  localparam logic [2:0] RA_STATUS = 3'h1;
  localparam logic [2:0] RA_ACC = 3'h2;
  localparam logic [2:0] RA_PCLO = 3'h3;
  // Control register layout and reset value.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PSA_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Phase of one instruction cycle.
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_READ = 3'b010,
    ST_EXEC = 3'b100
  } rcd_state_e;

  // Request toward the data-side file registers.
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wrData;
    logic we;
  } rcd_file_s;

  // Pin levels of the two I/O ports.
  typedef struct packed {
    logic [7:0] portA;
    logic [7:0] portB;
  } rcd_pins_s;

  // Whole state of the core.
  typedef struct packed {
    rcd_state_e st;
    logic [PC_W-1:0] pc;
    logic [13:0] ir;
    logic [7:0] w;
    logic carry;
    logic digitCarryFlag;
    logic zero;
    logic timeoutStatus;
    logic powerDownStatus;
    logic globalIntEnable;
    logic sleep;
    logic flush;
    logic [SP_W-1:0] sp;
    logic [STK_D-1:0][PC_W-1:0] stack;
    rcd_file_s file;
    logic psClr;
    logic wdtClr;
    logic [1:0] ctrl;
    logic [7:0] rdData;
  } rcd_core_s;
endpackage

/* File: logic/rcd_core.sv */
// Decode and execute logic of the 8-bit RISC core, with stack and flags.
// Assumes program memory answers one clock after the address and the file
// registers answer combinationally to the registered file address.
// How it works
// - Inclusive OR acc with file, zero only.
// - Exclusive OR acc with file, zero only.
// - Rotate file left through carry.
// - Rotate file right through carry.
// - Decrement file, skip on zero, flags kept.
// - Increment file, skip on zero, flags kept.
// - Bit test skips next when bit clear.
// - Bit test skips next when bit set.
// - OR literal into acc, zero only.
// - Literal minus acc sets carry, digit, zero.
// - Return loads literal, pops stack, two cycles.
// - Standby word updates timeout, power-down bits.
// - Clear file writes zero, sets zero.
// - Port self-modify uses pin levels.
// - Timer-zero write clears assigned prescaler.
// - Branch or skip costs a NOP cycle.
// - Interrupt return pops and sets global enable.
// - Interrupt entry clears enable, pushes, vectors.
// - External interrupt latency three or four cycles.
`timescale 1ns/1ps
`default_nettype none
module rcd_core
  import rcd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Program memory.
  output logic [PC_W-1:0] progAddr,
  input wire logic [13:0] instrWord,
  // File registers and port pins.
  output rcd_file_s fileReq,
  input wire logic [7:0] fileRdData,
  input wire rcd_pins_s portPins,
  // Interrupt request, already gated by the per-source masks.
  input wire logic intReq,
  // Timer and watchdog side effects.
  output logic prescalerClr,
  output logic watchdogClr,
  // Software register port.
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);

  // Adds with carry in; returns digit carry, carry and the sum.
  function automatic logic [9:0] addCarry(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {lo[4], full[8], full[7:0]};
  endfunction

  rcd_core_s s_q; // Registered state.
  rcd_core_s s_d; // Next state.
  logic [7:0] opnd; // File operand after the pin substitution.
  logic execNow; // A real instruction executes in this cycle.
  logic stackOp; // The held instruction pushes or pops the stack.
  logic intTake; // Interrupt entry happens at the end of this cycle.
  logic [SP_W-1:0] spDown; // Stack pointer after a pop.

  // Ports read back as the pin levels, not the output latches.
  assign opnd = (s_q.file.addr == FA_PORT_A) ? portPins.portA :
                (s_q.file.addr == FA_PORT_B) ? portPins.portB : fileRdData;
  assign execNow = (s_q.st == ST_EXEC) && !s_q.flush && !s_q.sleep;
  assign stackOp = ((s_q.ir[13:12] == CLS_JUMP) && !s_q.ir[11]) || (s_q.ir == W_RETURN) ||
                   (s_q.ir == W_RETFROMINT) || ((s_q.ir[13:12] == CLS_LIT) && (s_q.ir[11:10] == 2'b01));
  // Interrupts are sampled once per instruction cycle, so the latency does not
  // depend on whether the interrupted instruction takes one or two cycles.
  // A stack instruction defers entry by one cycle to avoid a double push.
  assign intTake = (s_q.st == ST_EXEC) && s_q.globalIntEnable && intReq && !(execNow && stackOp);
  assign spDown = s_q.sp - 3'd1;

  // Next-state logic: one instruction cycle is fetch, read and execute.
  always_comb begin
    logic [7:0] res;
    logic [9:0] alu;
    logic [7:0] mask;
    logic [PC_W-1:0] pcNext;
    logic toAcc;
    logic toFile;
    logic updZ;
    logic updC;
    logic updDc;
    logic cOut;
    logic skip;
    logic branch;
    res = 8'h00;
    alu = 10'h000;
    mask = 8'h01 << s_q.ir[9:7];
    pcNext = s_q.pc + 11'h001;
    toAcc = 1'b0;
    toFile = 1'b0;
    updZ = 1'b0;
    updC = 1'b0;
    updDc = 1'b0;
    cOut = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    s_d = s_q;
    s_d.file.we = 1'b0;
    s_d.psClr = 1'b0;
    s_d.wdtClr = 1'b0;
    s_d.rdData = 8'h00;
    // Register port: reads answer in the next cycle only.
    if (regRd) begin
      case (regAddr)
        RA_CTRL: s_d.rdData = {6'h00, s_q.ctrl};
        RA_STATUS: s_d.rdData = {s_q.sleep, s_q.globalIntEnable, 1'b0, s_q.timeoutStatus,
                                 s_q.powerDownStatus, s_q.zero, s_q.digitCarryFlag, s_q.carry};
        RA_ACC: s_d.rdData = s_q.w;
        RA_PCLO: s_d.rdData = s_q.pc[7:0];
        default: s_d.rdData = 8'h00;
      endcase
    end
    if (regWr && (regAddr == RA_CTRL)) begin
      s_d.ctrl = regWrData[1:0];
    end
    case (s_q.st)
      // The address stands for one clock while memory looks it up; the core waits here while the run bit is clear.
      ST_FETCH: begin
        if (s_q.ctrl[CTRL_RUN_BIT]) begin
          s_d.st = ST_READ;
        end
      end
      // Latch the word and present its file address.
      ST_READ: begin
        s_d.ir = instrWord;
        s_d.file.addr = instrWord[6:0];
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        s_d.st = ST_FETCH;
        s_d.flush = 1'b0;
        if (s_q.sleep) begin
          // Standby holds the counter; any request wakes the core.
          if (intReq) begin
            s_d.sleep = 1'b0;
          end
        end else if (s_q.flush) begin
          // The fetched word is discarded and the counter stands still.
          s_d.flush = 1'b0;
        end else begin
          case (s_q.ir[13:12])
            CLS_BYTE: begin
              toAcc = !s_q.ir[7];
              toFile = s_q.ir[7];
              case (s_q.ir[11:8])
                OP_MISC: begin
                  toAcc = 1'b0;
                  toFile = s_q.ir[7];
                  res = s_q.w;
                  if (s_q.ir == W_RETURN || s_q.ir == W_RETFROMINT) begin
                    pcNext = s_q.stack[spDown];
                    s_d.sp = spDown;
                    branch = 1'b1;
                    if (s_q.ir == W_RETFROMINT) begin
                      s_d.globalIntEnable = 1'b1;
                    end
                  end else if (s_q.ir == W_STANDBY) begin
                    s_d.timeoutStatus = 1'b1;
                    s_d.powerDownStatus = 1'b0;
                    s_d.sleep = 1'b1;
                  end else if (s_q.ir == W_WDOGCLR) begin
                    s_d.timeoutStatus = 1'b1;
                    s_d.powerDownStatus = 1'b1;
                    s_d.wdtClr = 1'b1;
                  end
                end
                OP_CLR: begin
                  res = 8'h00;
                  updZ = 1'b1;
                end
                OP_SUB, OP_ADD: begin
                  alu = addCarry(opnd, (s_q.ir[11:8] == OP_SUB) ? ~s_q.w : s_q.w, (s_q.ir[11:8] == OP_SUB));
                  res = alu[7:0];
                  cOut = alu[8];
                  updZ = 1'b1;
                  updC = 1'b1;
                  updDc = 1'b1;
                end
                OP_DEC: begin
                  res = opnd - 8'h01;
                  updZ = 1'b1;
                end
                OP_IOR: begin
                  res = opnd | s_q.w;
                  updZ = 1'b1;
                end
                OP_AND: begin
                  res = opnd & s_q.w;
                  updZ = 1'b1;
                end
                OP_XOR: begin
                  res = opnd ^ s_q.w;
                  updZ = 1'b1;
                end
                OP_MOV: begin
                  res = opnd;
                  updZ = 1'b1;
                end
                OP_COM: begin
                  res = ~opnd;
                  updZ = 1'b1;
                end
                OP_INC: begin
                  res = opnd + 8'h01;
                  updZ = 1'b1;
                end
                OP_DECSZ: begin
                  res = opnd - 8'h01;
                  skip = (res == 8'h00);
                end
                OP_INCSZ: begin
                  res = opnd + 8'h01;
                  skip = (res == 8'h00);
                end
                OP_RRC: begin
                  res = {s_q.carry, opnd[7:1]};
                  cOut = opnd[0];
                  updC = 1'b1;
                end
                OP_RLC: begin
                  res = {opnd[6:0], s_q.carry};
                  cOut = opnd[7];
                  updC = 1'b1;
                end
                OP_SWAP: begin
                  res = {opnd[3:0], opnd[7:4]};
                end
                default: begin
                  res = opnd;
                end
              endcase
            end
            CLS_BIT: begin
              case (s_q.ir[11:10])
                BOP_CLR: begin
                  res = opnd & ~mask;
                  toFile = 1'b1;
                end
                BOP_SET: begin
                  res = opnd | mask;
                  toFile = 1'b1;
                end
                BOP_SKIPCLR: skip = !opnd[s_q.ir[9:7]];
                BOP_SKIPSET: skip = opnd[s_q.ir[9:7]];
                default: skip = 1'b0;
              endcase
            end
            CLS_JUMP: begin
              // A call saves the address after itself before jumping.
              if (!s_q.ir[11]) begin
                s_d.stack[s_q.sp] = pcNext;
                s_d.sp = s_q.sp + 3'd1;
              end
              pcNext = s_q.ir[10:0];
              branch = 1'b1;
            end
            default: begin
              casez (s_q.ir[11:8])
                4'b00??: s_d.w = s_q.ir[7:0];
                4'b01??: begin
                  s_d.w = s_q.ir[7:0];
                  pcNext = s_q.stack[spDown];
                  s_d.sp = spDown;
                  branch = 1'b1;
                end
                4'b1000: begin
                  s_d.w = s_q.ir[7:0] | s_q.w;
                  s_d.zero = ((s_q.ir[7:0] | s_q.w) == 8'h00);
                end
                4'b1001: begin
                  s_d.w = s_q.ir[7:0] & s_q.w;
                  s_d.zero = ((s_q.ir[7:0] & s_q.w) == 8'h00);
                end
                4'b1010: begin
                  s_d.w = s_q.ir[7:0] ^ s_q.w;
                  s_d.zero = ((s_q.ir[7:0] ^ s_q.w) == 8'h00);
                end
                4'b110?, 4'b111?: begin
                  // Subtraction is the literal plus the complement plus one.
                  alu = addCarry(s_q.ir[7:0], s_q.ir[9] ? s_q.w : ~s_q.w, !s_q.ir[9]);
                  s_d.w = alu[7:0];
                  s_d.zero = (alu[7:0] == 8'h00);
                  s_d.carry = alu[8];
                  s_d.digitCarryFlag = alu[9];
                end
                default: s_d.w = s_q.w;
              endcase
            end
          endcase
          // Flag and destination updates of the byte and bit classes.
          if (updZ) begin
            s_d.zero = (res == 8'h00);
          end
          if (updC) begin
            s_d.carry = cOut;
          end
          if (updDc) begin
            s_d.digitCarryFlag = alu[9];
          end
          if (toAcc) begin
            s_d.w = res;
          end
          if (toFile) begin
            s_d.file.wrData = res;
            s_d.file.we = 1'b1;
            s_d.psClr = (s_q.file.addr == FA_TIMER_ZERO_COUNT) && s_q.ctrl[CTRL_PSA_BIT];
          end
          // A taken skip jumps over the next word and idles one cycle.
          if (skip) begin
            pcNext = s_q.pc + 11'h002;
          end
          s_d.flush = skip || branch;
          s_d.pc = pcNext;
        end
        if (intTake) begin
          s_d.stack[s_d.sp] = s_d.pc;
          s_d.sp = s_d.sp + 3'd1;
          s_d.pc = INT_VECTOR;
          s_d.globalIntEnable = 1'b0;
          s_d.flush = 1'b1;
          s_d.sleep = 1'b0;
        end
      end
      default: s_d.st = ST_FETCH;
    endcase
  end

  // State register; reset leaves interrupts off and both power bits set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.pc <= PC_RESET;
      s_q.timeoutStatus <= 1'b1;
      s_q.powerDownStatus <= 1'b1;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs come straight from the state register.
  assign progAddr = s_q.pc;
  assign fileReq = s_q.file;
  assign prescalerClr = s_q.psClr;
  assign watchdogClr = s_q.wdtClr;
  assign regRdData = s_q.rdData;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper view of the held word.
  logic isByte;
  assign isByte = execNow && (s_q.ir[13:12] == CLS_BYTE);

  property p_iorZero;
    isByte && s_q.ir[11:8] == OP_IOR |=> s_q.zero == ~|($past(opnd) | $past(s_q.w)) && $stable(s_q.carry);
  endproperty
  a_iorZero: assert property (p_iorZero) else $error("OR with file zero flag wrong");
  property p_xorZero;
    isByte && s_q.ir[11:8] == OP_XOR |=> s_q.zero == ~|($past(opnd) ^ $past(s_q.w)) && $stable(s_q.carry);
  endproperty
  a_xorZero: assert property (p_xorZero) else $error("XOR with file zero flag wrong");
  property p_rotLeft;
    isByte && s_q.ir[11:8] == OP_RLC |=> s_q.carry == $past(opnd[7]) && $stable(s_q.zero);
  endproperty
  a_rotLeft: assert property (p_rotLeft) else $error("left rotate carry wrong");
  property p_rotRight;
    isByte && s_q.ir[11:8] == OP_RRC |=> s_q.carry == $past(opnd[0]);
  endproperty
  a_rotRight: assert property (p_rotRight) else $error("right rotate carry wrong");
  property p_decSkip;
    isByte && s_q.ir[11:8] == OP_DECSZ && opnd == 8'h01 && !intTake |=> s_q.flush && $stable(s_q.zero);
  endproperty
  a_decSkip: assert property (p_decSkip) else $error("decrement skip missing");
  property p_bitClrSkip;
    execNow && s_q.ir[13:10] == 4'b0110 && !opnd[s_q.ir[9:7]] && !intTake |=> s_q.flush;
  endproperty
  a_bitClrSkip: assert property (p_bitClrSkip) else $error("bit clear skip missing");
  property p_subLit;
    execNow && s_q.ir[13:9] == 5'b11110 |=> s_q.carry == ($past(s_q.ir[7:0]) >= $past(s_q.w));
  endproperty
  a_subLit: assert property (p_subLit) else $error("literal minus acc carry wrong");
  property p_retLit;
    execNow && s_q.ir[13:10] == 4'b1101 |=> s_q.w == $past(s_q.ir[7:0]) && s_q.flush;
  endproperty
  a_retLit: assert property (p_retLit) else $error("return with literal wrong");
  property p_standby;
    execNow && s_q.ir == W_STANDBY && !intTake |=> s_q.sleep && !s_q.powerDownStatus && s_q.timeoutStatus;
  endproperty
  a_standby: assert property (p_standby) else $error("standby flags wrong");
  property p_clearFile;
    isByte && s_q.ir[11:7] == 5'b00011 |=> s_q.file.we && s_q.file.wrData == 8'h00 && s_q.zero;
  endproperty
  a_clearFile: assert property (p_clearFile) else $error("clear file wrong");
  property p_prescaler;
    s_d.file.we && s_q.file.addr == FA_TIMER_ZERO_COUNT && s_q.ctrl[CTRL_PSA_BIT] |=> prescalerClr;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");
  sequence s_jumpTaken;
    execNow && s_q.ir[13:12] == CLS_JUMP && !intTake;
  endsequence
  sequence s_deadCycle;
    s_q.flush ##3 (!s_q.flush && !s_q.file.we);
  endsequence
  property p_nopCycle;
    s_jumpTaken |=> s_deadCycle;
  endproperty
  a_nopCycle: assert property (p_nopCycle) else $error("branch NOP cycle wrong");
  property p_retInt;
    execNow && s_q.ir == W_RETFROMINT |=> s_q.globalIntEnable && s_q.sp == $past(spDown);
  endproperty
  a_retInt: assert property (p_retInt) else $error("interrupt return wrong");
  property p_intEntry;
    intTake |=> s_q.pc == INT_VECTOR && !s_q.globalIntEnable && s_q.flush;
  endproperty
  a_intEntry: assert property (p_intEntry) else $error("interrupt entry wrong");
  property p_destAcc;
    isByte && !s_q.ir[7] && s_q.ir[11:8] != OP_MISC |=> !s_q.file.we;
  endproperty
  a_destAcc: assert property (p_destAcc) else $error("acc destination wrote file");
  property p_jump;
    s_jumpTaken |=> s_q.pc == $past(s_q.ir[10:0]) && s_q.flush;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
endmodule
`default_nettype wire

/* File: tb/rcd_prog_mem.sv */
// Program memory model that supplies 14-bit instruction words to the core.
// Assumes the core holds progAddr steady for a whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module rcd_prog_mem
  import rcd_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Fetch port.
  input wire logic [PC_W-1:0] progAddr,
  output logic [13:0] instrWord
);
  // The bench loads the image; words it never loads read as no-operation.
  logic [13:0] mem [2**PC_W];

  // Clear the whole image at time zero.
  initial begin
    for (int i = 0; i < 2**PC_W; i++) mem[i] = 14'h0000;
  end

  // The read is registered, so a word is good only from the clock after its address.
  always @(posedge clk) begin
    instrWord <= mem[progAddr];
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench: runs a small program and checks file writes and registers.
// Assumes the core in logic/rcd_core.sv and the memory model in tb/rcd_prog_mem.sv.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rcd_pkg::*;
  logic clk;
  logic rst;
  logic [PC_W-1:0] progAddr;
  logic [13:0] instrWord;
  rcd_file_s fileReq;
  logic [7:0] fileRdData;
  rcd_pins_s portPins;
  logic intReq;
  logic prescalerClr;
  logic watchdogClr;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  // File registers as the core sees them; reads are combinational.
  logic [7:0] fileMem [128];
  logic [14:0] fileQ [$];
  logic [7:0] regQ [$];
  logic rdPend = 1'b0;
  logic [7:0] seed = 8'h40;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int psCnt = 0;
  int wdCnt = 0;
  // Main program at 0x40; entries are {file address, data} or instruction words.
  logic [13:0] mainProg [21] = '{14'h380F, 14'h06A0, 14'h0421, 14'h00A2, 14'h0DA3, 14'h0CA4, 14'h0BA5,
    14'h01A6, 14'h0FA7, 14'h1828, 14'h01A9, 14'h1C28, 14'h01AA, 14'h3C05, 14'h00AB, 14'h0485,
    14'h0181, 14'h2020, 14'h00AC, 14'h2030, 14'h0063};
  logic [15:0] initTab [8] = '{16'h20FF, 16'h2130, 16'h2381, 16'h2402, 16'h2501, 16'h2710, 16'h2801, 16'h05FF};

  always #25 clk = ~clk;
  assign fileRdData = fileMem[fileReq.addr[6:0]];

  rcd_prog_mem pm (.clk(clk), .progAddr(progAddr), .instrWord(instrWord));
  rcd_core dut (.clk(clk), .rst(rst), .progAddr(progAddr), .instrWord(instrWord), .fileReq(fileReq),
    .fileRdData(fileRdData), .portPins(portPins), .intReq(intReq), .prescalerClr(prescalerClr),
    .watchdogClr(watchdogClr), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));

  // Step of the bench's pseudo-random source.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Count a comparison and report a mismatch at once.
  task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Single end of the run.
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle register port strobes.
  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    regQ.push_back(exp);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  // Watcher: every write pulse and read answer is matched to the oldest note.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      num_errors++;
      tally_and_finish();
    end
    if (prescalerClr === 1'b1) psCnt++;
    if (watchdogClr === 1'b1) wdCnt++;
    if (rdPend) check("register read", {7'h00, regRdData}, regQ.size() ? {7'h00, regQ.pop_front()} : 'x);
    rdPend <= regRd;
    if (fileReq.we === 1'b1) begin
      fileMem[fileReq.addr] <= fileReq.wrData;
      check("file write", {fileReq.addr, fileReq.wrData}, fileQ.size() ? fileQ.pop_front() : 'x);
    end
  end

  initial begin
    // Inputs start idle here rather than at their declarations.
    clk = 1'b0;
    rst = 1'b1;
    portPins = '{portA: 8'h11, portB: 8'h00};
    intReq = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    for (int i = 0; i < 128; i++) fileMem[i] = 8'h00;
    foreach (initTab[i]) fileMem[initTab[i][14:8]] = initTab[i][7:0];
    repeat (2) @(posedge clk);
    pm.mem[0] = 14'h2840;
    // The handler clears the watchdog, stores W and then parks in a loop.
    pm.mem[4] = 14'h0064;
    pm.mem[5] = 14'h00AD;
    pm.mem[6] = 14'h2806;
    pm.mem[11'h020] = 14'h3444;
    pm.mem[11'h030] = 14'h0009;
    foreach (mainProg[i]) pm.mem[11'h040 + i] = mainProg[i];
    fileQ = '{15'h20F0, 15'h223F, 15'h2302, 15'h2481};
    fileQ.push_back(15'h2500);
    fileQ.push_back(15'h2711);
    fileQ.push_back(15'h2900);
    fileQ.push_back(15'h2BC6);
    fileQ.push_back(15'h05D7);
    fileQ.push_back(15'h0100);
    fileQ.push_back(15'h2C44);
    fileQ.push_back(15'h2D44);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    regWrite(RA_CTRL, 8'h03);
    // Writes to read-only indexes and reads of unmapped ones, all refused.
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      portPins.portB <= seed;
      regWrite((seed[1:0] == 2'h0) ? 3'h1 : {1'b0, seed[1:0]}, lfsr(seed));
      regRead({1'b1, seed[3:2]}, 8'h00);
    end
    while (progAddr !== 11'h055) @(posedge clk);
    // Asleep with interrupts re-enabled by the return, power-down bit low.
    regRead(RA_STATUS, 8'hD4);
    repeat (6) @(posedge clk);
    intReq <= 1'b1;
    while (fileQ.size() != 0) @(posedge clk);
    intReq <= 1'b0;
    $display("program run done");
    // Awake, enable cleared by entry, both power bits set by the watchdog clear.
    regRead(RA_STATUS, 8'h1C);
    regRead(RA_ACC, 8'h44);
    regRead(RA_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    check("prescaler clears", 15'(psCnt), 15'h0001);
    check("watchdog clears", 15'(wdCnt), 15'h0001);
    $display("register checks done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
